// ===== dv/crs_core_model.sv
`default_nettype none
module crs_core_model (
	input wire logic	clk,
	input wire logic	coreReset_q,
	input wire logic [31:0]	bootAddr_q,
	output var logic [31:0]	fetchAddr
);
	timeunit 1ns;
	timeprecision 1ps;
	// first fetch taken from the boot address as reset lets go
	always @(posedge clk) if ($fell(coreReset_q)) fetchAddr <= bootAddr_q;
endmodule // crs_core_model
`default_nettype wire

// ===== dv/crs_seq_monitor.sv
`default_nettype none
module crs_seq_monitor (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	resetPinN,
	input wire logic	watchdogReset,
	input wire logic	brownoutStage1,
	input wire logic	brownoutStage2,
	input wire logic	oscRunning,
	input wire logic	flashInitDone,
	input wire logic	coreReset_q,
	input wire logic	periphReset_q,
	input wire logic [31:0]	bootAddr_q,
	input wire logic	brownoutIrq_q,
	input wire logic	brownoutStatus_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// low long enough to get through the pin synchroniser
	sequence pinLow; !resetPinN [*4]; endsequence
	AST_PIN: assert property (pinLow |-> ##[0:2] coreReset_q)
		else $error("pin reset missed");
	AST_WD: assert property (watchdogReset |-> ##[0:3] coreReset_q)
		else $error("watchdog reset missed");
	AST_BO2: assert property (brownoutStage2 [*4] |-> ##[0:2] coreReset_q)
		else $error("brownout reset missed");
	AST_IRQ: assert property (brownoutStage1 [*7] |-> brownoutIrq_q)
		else $error("brownout irq missed");
	AST_NIRQ: assert property (!brownoutStage1 [*7] |-> !brownoutIrq_q)
		else $error("brownout irq stuck");
	AST_STAT: assert property (brownoutStatus_q == brownoutIrq_q)
		else $error("status differs from irq");
	AST_PER: assert property (periphReset_q == coreReset_q)
		else $error("peripheral reset differs");
	AST_BOOT: assert property (bootAddr_q == 32'h0000_0000)
		else $error("boot address not zero");
	AST_REL: assert property ($fell(coreReset_q) |->
		$past(resetPinN) && $past(oscRunning) && $past(flashInitDone))
		else $error("early reset release");
endmodule // crs_seq_monitor
`default_nettype wire

// ===== dv/crs_sequencer_bench.sv
`default_nettype none
module crs_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, pinN = 0, wdog = 0, por = 0, bo1 = 0, bo2 = 0, osc = 1, fl = 1;
	logic pdx = 0;
	wire logic cr, pr, irq, st, crq;
	wire logic [31:0] boot, fetch;
	int errCount = 0, checkCount = 0, cyc = 0;
	// osc pin wdog por bo1 bo2 flash | reset irq
	logic [8:0] rows [10] = '{9'h184, 9'h195, 9'h106, 9'h1C6, 9'h1A6,
		9'h18E, 9'h19F, 9'h182, 9'h086, 9'h184};
	always #10 clk = ~clk;
	crs_sequencer #(.WAKE_CYCLES(8)) dut (.clk(clk), .rst(rst), .resetPinN(pinN),
		.watchdogReset(wdog), .powerOnDetect(por), .brownoutStage1(bo1),
		.brownoutStage2(bo2), .oscRunning(osc), .flashInitDone(fl), .powerDownExit(pdx),
		.coreReset_q(cr), .periphReset_q(pr), .bootAddr_q(boot), .brownoutIrq_q(irq),
		.brownoutStatus_q(st), .chipResetReq_q(crq));
	crs_core_model core (.clk(clk), .coreReset_q(cr), .bootAddr_q(boot), .fetchAddr(fetch));
	task automatic chk(input logic [31:0] got, exp);
		checkCount++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finishTest;
		if (errCount == 0 && checkCount > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			errCount++;
			finishTest();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 0;
		foreach (rows[i]) begin
			{osc, pinN, wdog, por, bo1, bo2, fl} = rows[i][8:2];
			repeat (20) @(posedge clk);
			#1 chk(32'({cr, pr, irq, st}), 32'({rows[i][1], rows[i][1:0], rows[i][0]}));
		end
		chk(fetch, 32'h0000_0000);
		pinN = 0;
		repeat (6) @(posedge clk);
		#1 pinN = 1;
		// sync plus eight counted edges cannot be done yet
		repeat (8) @(posedge clk);
		#1 chk(32'(cr), 32'h1);
		repeat (12) @(posedge clk);
		#1 chk(32'(cr), 32'h0);
		pdx = 1;
		@(posedge clk);
		#1 pdx = 0;
		@(posedge clk);
		#1 chk(32'(cr), 32'h1);
		repeat (12) @(posedge clk);
		#1 chk(32'(cr), 32'h0);
		rst = 1;
		repeat (2) @(posedge clk);
		#1 chk(32'({cr, pr, crq, irq}), 32'hE);
		finishTest();
	end
endmodule // crs_sequencer_bench
bind crs_sequencer crs_seq_monitor mon (.*);
`default_nettype wire

// ===== hdl/crs_consts.vh
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
// ----------------------------------------------------------------
// wake-up timing
// ----------------------------------------------------------------
`define CRS_CLK_HZ        50000000
`define CRS_WAKE_CYCLES   4096
`define CRS_CNT_W         13
// ----------------------------------------------------------------
// start-up fetch address and reset value
// ----------------------------------------------------------------
`define CRS_BOOT_ADDR     32'h0000_0000
`define CRS_SYNC_RST      3'h7
`endif

// ===== hdl/crs_sequencer.v
`include "crs_consts.vh"
`default_nettype none
module crs_sequencer #(
	parameter WAKE_CYCLES = `CRS_WAKE_CYCLES
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        resetPinN,
	input  wire        watchdogReset,
	input  wire        powerOnDetect,
	input  wire        brownoutStage1,
	input  wire        brownoutStage2,
	input  wire        oscRunning,
	input  wire        flashInitDone,
	input  wire        powerDownExit,
	output reg         coreReset_q,
	output reg         periphReset_q,
	output reg  [31:0] bootAddr_q,
	output reg         brownoutIrq_q,
	output reg         brownoutStatus_q,
	output reg         chipResetReq_q
);
	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam integer     CNT_W     = `CRS_CNT_W;
	localparam [2:0]       ST_HOLD   = 3'h1;
	localparam [2:0]       ST_WAIT   = 3'h2;
	localparam [2:0]       ST_RUN    = 3'h4;
	localparam integer     WAKE_END  = WAKE_CYCLES - 1;
	// counter width is fixed; a longer wake count needs a wider counter
	localparam [CNT_W-1:0] WAKE_LAST = WAKE_END[CNT_W-1:0];
	localparam [CNT_W-1:0] CNT_ZERO  = {CNT_W{1'h0}};

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// a change counts once stages two and three agree, so a single
	// glitch never flips state; costs four edges of latency
	reg [2:0] pinSync_q;
	reg [2:0] porSync_q;
	reg [2:0] bod1Sync_q;
	reg [2:0] bod2Sync_q;
	reg       pinRel_q;
	reg       por_q;
	reg       bod1_q;
	reg       bod2_q;

	function agree;
		input [2:0] s;
		input       old;
		begin
			agree = (s[1] == s[2]) ? s[2] : old;
		end
	endfunction

	// external pin, released when high
	always @(posedge clk) begin
		if (rst) begin
			pinSync_q <= 3'h0;
			pinRel_q  <= 1'h0;
		end else begin
			pinSync_q <= {pinSync_q[1:0], resetPinN};
			pinRel_q  <= agree(pinSync_q, pinRel_q);
		end
	end

	// power-on detector, taken as asserted until the stages agree
	always @(posedge clk) begin
		if (rst) begin
			porSync_q <= `CRS_SYNC_RST;
			por_q     <= 1'h1;
		end else begin
			porSync_q <= {porSync_q[1:0], powerOnDetect};
			por_q     <= agree(porSync_q, por_q);
		end
	end

	// first brownout stage
	always @(posedge clk) begin
		if (rst) begin
			bod1Sync_q <= 3'h0;
			bod1_q     <= 1'h0;
		end else begin
			bod1Sync_q <= {bod1Sync_q[1:0], brownoutStage1};
			bod1_q     <= agree(bod1Sync_q, bod1_q);
		end
	end

	// second brownout stage
	always @(posedge clk) begin
		if (rst) begin
			bod2Sync_q <= 3'h0;
			bod2_q     <= 1'h0;
		end else begin
			bod2Sync_q <= {bod2Sync_q[1:0], brownoutStage2};
			bod2_q     <= agree(bod2Sync_q, bod2_q);
		end
	end

	// ----------------------------------------------------------------
	// reset sequencing
	// ----------------------------------------------------------------
	// watchdog and oscillator/flash come from logic on this clock
	wire anySource = ~pinRel_q | watchdogReset | por_q | bod2_q;
	wire ready     = pinRel_q & oscRunning & flashInitDone;

	reg [2:0]       state_q;
	reg [2:0]       state_d;
	reg [CNT_W-1:0] cnt_q;
	reg [CNT_W-1:0] cnt_d;

	always @* begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_HOLD: begin
				cnt_d = CNT_ZERO;
				if (!anySource)
					state_d = ST_WAIT;
			end
			ST_WAIT: begin
				if (anySource) begin
					state_d = ST_HOLD;
				end else if (!oscRunning) begin
					cnt_d = CNT_ZERO;
				end else if (cnt_q != WAKE_LAST) begin
					cnt_d = cnt_q + {{(CNT_W-1){1'h0}}, 1'h1};
				end else if (ready) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (anySource)
					state_d = ST_HOLD;
				else if (powerDownExit)
					state_d = ST_WAIT;
				cnt_d = CNT_ZERO;
			end
			default: begin
				state_d = ST_HOLD;
				cnt_d   = CNT_ZERO;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			state_q <= ST_HOLD;
			cnt_q   <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// next output values
	// ----------------------------------------------------------------
	reg coreReset_d;
	reg periphReset_d;
	reg brownoutIrq_d;
	reg brownoutStatus_d;
	reg chipResetReq_d;

	always @* begin
		// peripherals leave reset together with the core, never earlier
		coreReset_d      = (state_d != ST_RUN);
		periphReset_d    = (state_d != ST_RUN);
		brownoutIrq_d    = bod1_q;
		brownoutStatus_d = bod1_q;
		chipResetReq_d   = anySource;
	end

	// ----------------------------------------------------------------
	// core and peripheral reset
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			coreReset_q   <= 1'h1;
			periphReset_q <= 1'h1;
		end else begin
			coreReset_q   <= coreReset_d;
			periphReset_q <= periphReset_d;
		end
	end

	// ----------------------------------------------------------------
	// fetch address
	// ----------------------------------------------------------------
	// held constant; the core only reads it as reset lets go
	always @(posedge clk) begin
		if (rst) begin
			bootAddr_q <= `CRS_BOOT_ADDR;
		end else begin
			bootAddr_q <= `CRS_BOOT_ADDR;
		end
	end

	// ----------------------------------------------------------------
	// brownout interrupt and status
	// ----------------------------------------------------------------
	// a level with no clear: it drops once the supply recovers
	always @(posedge clk) begin
		if (rst) begin
			brownoutIrq_q    <= 1'h0;
			brownoutStatus_q <= 1'h0;
		end else begin
			brownoutIrq_q    <= brownoutIrq_d;
			brownoutStatus_q <= brownoutStatus_d;
		end
	end

	// ----------------------------------------------------------------
	// reset request summary
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			chipResetReq_q <= 1'h1;
		end else begin
			chipResetReq_q <= chipResetReq_d;
		end
	end
endmodule // crs_sequencer
`default_nettype wire
